// ===== hdl/burner_lockout_sequencer.sv
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module burner_lockout_sequencer
  import burner_pkg::*;
#(
  parameter int TICK_CYC   = TICK_CYCLES,
  parameter int AIR_WAIT_T = AIR_WAIT_TICKS
)(
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  input  logic        int_button_i,
  input  logic        remote_reset_button_i,
  input  logic        air_flow_switch_i,
  input  logic        flame_i,
  input  logic        thermostat_i,
  input  logic        mains_above_187_i,
  input  logic        mains_below_160_i,
  input  logic [2:0]  nv_cause_i,
  output logic        nv_we_o,
  output logic [2:0]  nv_cause_o,
  output loads_t      loads_o,
  output logic        remote_lockout_signal_o,
  output logic        led_o
);
  localparam int         PW  = $clog2(TICK_CYC);
  localparam logic [PW-1:0] PRE_END = PW'(TICK_CYC - 1);

  state_t         state_q, state_d;
  cause_t         cause_q, cause_d;
  logic           attempt_q, attempt_d, init_q, nvwe_q, nvwe_d;
  logic [PW-1:0]  pre_q, pre_d;
  logic           tick;
  logic [TMR_W-1:0] tmr_q, tmr_d, lim, hold_q, hold_d;
  logic           btn, btn_q, man_rel, rst_req, active, tmr_end;
  pins_t          raw, in;
  loads_t         loads_q, loads_d;
  logic           ctrl_en_q, ctrl_en_d, swrst_q, swrst_d, ack_q, ack_d;
  logic [31:0]    dat_q, dat_d;

  // every sequencing input passes the conditioner first
  assign raw = '{mains_low: mains_below_160_i, mains_ok: mains_above_187_i,
                 demand: thermostat_i, flame: flame_i, air_flow_switch: air_flow_switch_i,
                 remote_reset_button: remote_reset_button_i, int_button: int_button_i};

  input_conditioner #(.N(PIN_N), .DEB(DEB_TICKS)) u_cond (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (tick),
    .raw_i   (raw),
    .clean_o (in)
  );

  // both buttons share one function
  assign btn     = in.int_button | in.remote_reset_button;
  assign man_rel = btn_q && !btn && (hold_q > TMR_W'(HOLD_TICKS));
  assign rst_req = (btn_q && !btn) || swrst_q;
  assign active  = state_q inside {S_AIRCHK, S_AIRWT, S_PURGE, S_PREIGN, S_SAFETY, S_DELAY2, S_RUN};

  // duration of the current step
  always_comb begin
    lim = {TMR_W{1'b1}};
    case (state_q)
      S_AIRCHK, S_PWRFAN: lim = TMR_W'(FAN_TICKS);
      S_AIRWT:  lim = TMR_W'(AIR_WAIT_T);
      S_PURGE:  lim = TMR_W'(PREPURGE_TICKS);
      S_PREIGN: lim = TMR_W'(PREIGN_TICKS);
      S_SAFETY: lim = TMR_W'(SAFETY_TICKS);
      S_DELAY2: lim = TMR_W'(DELAY2_TICKS);
      S_QUICK:  lim = TMR_W'(QUICK_TICKS);
      default:  lim = {TMR_W{1'b1}};
    endcase
  end
  assign tmr_end = (tmr_q >= lim);

  // sequence: global aborts first, then per-step checks
  always_comb begin
    state_d   = state_q;
    cause_d   = cause_q;
    attempt_d = attempt_q;
    nvwe_d    = 1'b0;
    if (!init_q) begin
      cause_d = cause_t'(nv_cause_i); // stored cause survives power loss
    end else if (active && in.mains_low) begin
      state_d = S_UVLO;
    end else if (active && man_rel) begin
      state_d = S_LOCK;
      cause_d = C_MANUAL;
    end else if (active && !(in.demand && ctrl_en_q)) begin
      state_d = S_IDLE; // daily thermostat opening ends here
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (cause_q != C_NONE) begin
            state_d = S_PWRFAN;
          end else if (in.demand && ctrl_en_q && in.mains_ok) begin
            attempt_d = 1'b0;
            state_d   = in.air_flow_switch ? S_AIRCHK : S_AIRWT;
          end
        end
        S_AIRCHK: if (tmr_end) begin
          if (!attempt_q) begin
            state_d   = S_QUICK;
            attempt_d = 1'b1;
          end else begin
            // only a switch still closed at retry gets here; a running fan would close a sound one
            state_d = S_LOCK;
            cause_d = C_WELD;
          end
        end
        S_AIRWT: begin
          if (in.air_flow_switch) begin
            state_d = S_PURGE;
          end else if (tmr_end) begin
            state_d = S_LOCK;
            cause_d = C_AIRTMO;
          end
        end
        S_PURGE: begin
          if (!in.air_flow_switch) begin
            state_d = S_LOCK;
            cause_d = C_AIROPN;
          end else if (in.flame && tmr_q >= lim - TMR_W'(STRAY_TICKS)) begin
            state_d = S_LOCK;
            cause_d = C_STRAY;
          end else if (tmr_end) begin
            state_d = S_PREIGN;
          end
        end
        S_PREIGN, S_SAFETY, S_DELAY2, S_RUN: begin
          if (!in.air_flow_switch) begin
            state_d = S_LOCK;
            cause_d = C_AIROPN;
          end else if (state_q == S_SAFETY) begin
            if (tmr_end) begin
              state_d = in.flame ? S_DELAY2 : S_LOCK;
              cause_d = in.flame ? cause_q : C_SAFETY;
            end
          end else if (state_q != S_PREIGN && !in.flame) begin
            state_d = S_LOCK;
            cause_d = C_FLLOSS;
          end else if (tmr_end && state_q != S_RUN) begin
            state_d = (state_q == S_PREIGN) ? S_SAFETY : S_RUN;
          end
        end
        // the switch is judged with the fan stopped, before the retry spins it up again
        S_QUICK:  if (tmr_end) state_d = in.air_flow_switch ? S_AIRCHK : S_AIRWT;
        S_PWRFAN: if (tmr_end) state_d = S_LOCK;
        S_LOCK: begin
          if (rst_req) begin
            state_d = S_IDLE;
            cause_d = C_NONE;
            nvwe_d  = 1'b1;
          end
        end
        S_UVLO:   if (in.mains_ok) state_d = S_IDLE;
      endcase
    end
    if (state_d == S_LOCK && state_q != S_LOCK) begin
      nvwe_d = 1'b1;
    end
  end

  // loads follow the next state so they drop on the entering edge
  always_comb begin
    loads_d.fan                = state_d inside {S_AIRCHK, S_AIRWT, S_PURGE, S_PREIGN,
                                                 S_SAFETY, S_DELAY2, S_RUN, S_PWRFAN};
    loads_d.ignition           = state_d inside {S_PREIGN, S_SAFETY};
    loads_d.first_stage_valve  = state_d inside {S_SAFETY, S_DELAY2, S_RUN};
    loads_d.second_stage_valve = (state_d == S_RUN);
  end

  // timebase, step timer and button hold timer
  always_comb begin
    pre_d  = (pre_q == PRE_END) ? '0 : pre_q + 1'b1;
    tmr_d  = (state_d != state_q) ? '0 : (tmr_end ? tmr_q : tmr_q + TMR_W'(tick));
    hold_d = !btn ? '0 : ((hold_q > TMR_W'(HOLD_TICKS)) ? hold_q : hold_q + TMR_W'(tick));
  end
  assign tick = (pre_q == PRE_END);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= S_IDLE;
      cause_q   <= C_NONE;
      attempt_q <= 1'b0;
      init_q    <= 1'b0;
      nvwe_q    <= 1'b0;
      loads_q   <= '0;
      pre_q     <= '0;
      tmr_q     <= '0;
      hold_q    <= '0;
      btn_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      cause_q   <= cause_d;
      attempt_q <= attempt_d;
      init_q    <= 1'b1;
      nvwe_q    <= nvwe_d;
      loads_q   <= loads_d;
      pre_q     <= pre_d;
      tmr_q     <= tmr_d;
      hold_q    <= hold_d;
      btn_q     <= btn;
    end
  end

  // wishbone slave: ack one cycle after the strobe, write on the acked edge
  always_comb begin
    ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
    ctrl_en_d = ctrl_en_q;
    swrst_d   = 1'b0;
    dat_d     = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
      ctrl_en_d = wb_dat_i[CTRL_EN];
      swrst_d   = wb_dat_i[CTRL_RST]; // software reset pulse, same path as the button
    end
    if (ack_d && !wb_we_i) begin
      if (wb_adr_i == REG_CTRL) begin
        dat_d[CTRL_EN] = ctrl_en_q;
      end else if (wb_adr_i == REG_STATUS) begin
        dat_d[ST_STATE_LSB +: 12]   = state_q;
        dat_d[ST_CAUSE_LSB +: 3]    = cause_q;
        dat_d[ST_ATTEMPT]           = attempt_q;
        dat_d[ST_MAINS]             = in.mains_ok;
        dat_d[ST_AIR]               = in.air_flow_switch;
        dat_d[ST_FLAME]             = in.flame;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q     <= 1'b0;
      ctrl_en_q <= CTRL_EN_RST;
      swrst_q   <= 1'b0;
      dat_q     <= 32'h0000_0000;
    end else begin
      ack_q     <= ack_d;
      ctrl_en_q <= ctrl_en_d;
      swrst_q   <= swrst_d;
      dat_q     <= dat_d;
    end
  end

  lockout_indicator u_ind (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .locked_i (state_q == S_LOCK),
    .cause_i  (cause_q),
    .led_o    (led_o)
  );

  assign wb_ack_o                = ack_q;
  assign wb_dat_o                = dat_q;
  assign loads_o                 = loads_q;
  assign nv_we_o                 = nvwe_q;
  assign nv_cause_o              = cause_q;
  assign remote_lockout_signal_o = (state_q == S_LOCK);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_LOCK_LOADS_OFF: assert property ($rose(state_q == S_LOCK) |-> loads_q == '0)
    else $error("loads still on in lockout");
  AST_START_MAINS: assert property (state_q == S_IDLE && state_d inside {S_AIRCHK, S_AIRWT}
    |-> in.mains_ok)
    else $error("start without mains");
  AST_UV_LOCK: assert property (init_q && active && in.mains_low |=> state_q == S_UVLO)
    else $error("undervoltage ignored");
  AST_UV_RESTART: assert property (state_q == S_UVLO && in.mains_ok |=> state_q == S_IDLE)
    else $error("no restart after undervoltage");
  AST_SAFETY_LOCK: assert property (state_q == S_SAFETY && tmr_end && !in.flame && in.air_flow_switch
    && !in.mains_low && in.demand && ctrl_en_q |=> state_q == S_LOCK && cause_q inside {C_SAFETY, C_MANUAL})
    else $error("no lockout at safety end");
  AST_AIR_OPEN: assert property (init_q && state_q inside {S_PURGE, S_RUN} && !in.air_flow_switch
    && !in.mains_low && !man_rel && in.demand && ctrl_en_q |=> state_q == S_LOCK)
    else $error("air switch opening ignored");
  AST_LOCK_HOLD: assert property (state_q == S_LOCK && !rst_req |=> state_q == S_LOCK
    && $stable(cause_q))
    else $error("lockout left without reset");
  AST_NV_WRITE: assert property ($rose(state_q == S_LOCK) |-> nv_we_o && nv_cause_o == cause_q)
    else $error("cause not stored");
  AST_QUICK_RETRY: assert property (state_q == S_QUICK && tmr_end && in.air_flow_switch
    |=> state_q == S_AIRCHK ##1 loads_q.fan)
    else $error("quick lockout not retried");
  AST_QUICK_OPEN: assert property (state_q == S_QUICK && tmr_end && !in.air_flow_switch
    |=> state_q == S_AIRWT && loads_q.fan)
    else $error("opened switch did not start normally");

  COV_RUN: cover property (state_q == S_DELAY2 ##1 state_q == S_RUN);
  COV_QUICK: cover property (state_q == S_QUICK ##1 state_q == S_AIRCHK);
  COV_RESET: cover property (state_q == S_LOCK ##1 state_q == S_IDLE);
endmodule : burner_lockout_sequencer

// ===== inc/burner_pkg.sv
package burner_pkg;
  // clock and timebase
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // sequence times in ms, as printed
  localparam int AIR_WAIT_MS  = 60000;
  localparam int PREPURGE_MS  = 24000;
  localparam int STRAY_MS     = 5000;
  localparam int PREIGN_MS    = 3000;
  localparam int SAFETY_MS    = 3000;
  localparam int DELAY2_MS    = 12500;
  localparam int FAN_CHECK_MS = 2500;
  localparam int QUICK_MS     = 10000;
  localparam int HOLD_MS      = 3000;
  localparam int LIT_MS       = 10000;
  localparam int DARK_MS      = 600;
  localparam int CODE_MS      = 1200;
  localparam int SLOT_MS      = 200;
  localparam int DEB_MS       = 20;

  // the same times in ticks
  localparam int TMR_W          = 13;
  localparam int AIR_WAIT_TICKS = AIR_WAIT_MS / TICK_MS;
  localparam int PREPURGE_TICKS = PREPURGE_MS / TICK_MS;
  localparam int STRAY_TICKS    = STRAY_MS / TICK_MS;
  localparam int PREIGN_TICKS   = PREIGN_MS / TICK_MS;
  localparam int SAFETY_TICKS   = SAFETY_MS / TICK_MS;
  localparam int DELAY2_TICKS   = DELAY2_MS / TICK_MS;
  localparam int FAN_TICKS      = FAN_CHECK_MS / TICK_MS;
  localparam int QUICK_TICKS    = QUICK_MS / TICK_MS;
  localparam int HOLD_TICKS     = HOLD_MS / TICK_MS;
  localparam int LIT_TICKS      = LIT_MS / TICK_MS;
  localparam int DARK_TICKS     = DARK_MS / TICK_MS;
  localparam int CODE_TICKS     = CODE_MS / TICK_MS;
  localparam int SLOT_TICKS     = SLOT_MS / TICK_MS;
  localparam int DEB_TICKS      = DEB_MS / TICK_MS;

  // register map
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam int         CTRL_EN     = 0;
  localparam int         CTRL_RST    = 1;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam int         ST_STATE_LSB = 0;
  localparam int         ST_CAUSE_LSB = 12;
  localparam int         ST_ATTEMPT   = 15;
  localparam int         ST_MAINS     = 16;
  localparam int         ST_AIR       = 17;
  localparam int         ST_FLAME     = 18;

  typedef enum logic [11:0] {
    S_IDLE   = 12'h001,
    S_AIRCHK = 12'h002,
    S_AIRWT  = 12'h004,
    S_PURGE  = 12'h008,
    S_PREIGN = 12'h010,
    S_SAFETY = 12'h020,
    S_DELAY2 = 12'h040,
    S_RUN    = 12'h080,
    S_QUICK  = 12'h100,
    S_LOCK   = 12'h200,
    S_PWRFAN = 12'h400,
    S_UVLO   = 12'h800
  } state_t;

  typedef enum logic [2:0] {
    C_NONE   = 3'h0,
    C_SAFETY = 3'h1,
    C_STRAY  = 3'h2,
    C_WELD   = 3'h3,
    C_AIRTMO = 3'h4,
    C_AIROPN = 3'h5,
    C_FLLOSS = 3'h6,
    C_MANUAL = 3'h7
  } cause_t;

  typedef struct packed {
    logic second_stage_valve;
    logic first_stage_valve;
    logic ignition;
    logic fan;
  } loads_t;

  typedef struct packed {
    logic mains_low;
    logic mains_ok;
    logic demand;
    logic flame;
    logic air_flow_switch;
    logic remote_reset_button;
    logic int_button;
  } pins_t;

  localparam int PIN_N = $bits(pins_t);
endpackage : burner_pkg

// ===== hdl/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner
  import burner_pkg::*;
#(
  parameter int N   = PIN_N,
  parameter int DEB = DEB_TICKS
)(
  input  logic         clk_i,
  input  logic         rst_i,
  input  logic         tick_i,
  input  logic [N-1:0] raw_i,
  output logic [N-1:0] clean_o
);
  localparam logic [7:0] DEB_C = 8'(DEB);

  // per pin: two-stage synchroniser, then a tick-counted debounce
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic       s1_q, s2_q, lvl_q, lvl_d;
    logic [7:0] cnt_q, cnt_d;

    always_comb begin
      lvl_d = lvl_q;
      cnt_d = 8'h00;
      if (s2_q != lvl_q) begin
        cnt_d = cnt_q + {7'h00, tick_i};
        if (cnt_q >= DEB_C) begin
          lvl_d = s2_q;
          cnt_d = 8'h00;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q  <= 1'b0;
        s2_q  <= 1'b0;
        lvl_q <= 1'b0;
        cnt_q <= 8'h00;
      end else begin
        s1_q  <= raw_i[i];
        s2_q  <= s1_q;
        lvl_q <= lvl_d;
        cnt_q <= cnt_d;
      end
    end

    assign clean_o[i] = lvl_q;
  end
endmodule : input_conditioner

// ===== hdl/lockout_indicator.sv
`timescale 1ns/1ps
module lockout_indicator
  import burner_pkg::*;
(
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic       tick_i,
  input  logic       locked_i,
  input  cause_t     cause_i,
  output logic       led_o
);
  localparam logic [10:0] DARK_AT = 11'(LIT_TICKS);
  localparam logic [10:0] CODE_AT = 11'(LIT_TICKS + DARK_TICKS);
  localparam logic [10:0] WRAP    = 11'(LIT_TICKS + DARK_TICKS + CODE_TICKS - 1);
  // eight slots fill the code window, so even the highest cause gets all of its flashes
  localparam logic [10:0] SLOT    = 11'(CODE_TICKS / 8);
  localparam logic [10:0] HALF    = 11'(CODE_TICKS / 16);

  logic [10:0] ph_q, ph_d, off;
  logic        led_q, led_d;

  // lit phase, dark gap, then one short flash per cause step
  always_comb begin
    off   = ph_q - CODE_AT;
    ph_d  = ph_q;
    led_d = 1'b0;
    if (locked_i) begin
      if (tick_i) begin
        ph_d = (ph_q == WRAP) ? 11'h000 : ph_q + 11'h001;
      end
      if (ph_q < DARK_AT) begin
        led_d = 1'b1;
      end else if (ph_q >= CODE_AT) begin
        led_d = ((off / SLOT) < {8'h00, cause_i}) && ((off % SLOT) < HALF);
      end
    end else begin
      ph_d = 11'h000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q  <= 11'h000;
      led_q <= 1'b0;
    end else begin
      ph_q  <= ph_d;
      led_q <= led_d;
    end
  end

  assign led_o = led_q;
endmodule : lockout_indicator

// ===== tb/burner_far_side.sv
`timescale 1ns/1ps
// far side: air switch and flame detector answering the loads
module burner_far_side
  import burner_pkg::*;
(
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic [2:0] mode_i,
  input  loads_t     loads_i,
  output logic       air_flow_switch_o,
  output logic       flame_o
);
  logic [15:0] fan_q;
  logic [15:0] v2_q;

  // time on for fan and second valve; a real fan needs spin-up before air proves
  always_ff @(posedge clk_i) begin
    fan_q <= (rst_i || !loads_i.fan) ? 16'h0 : fan_q + 16'h1;
    v2_q  <= (rst_i || !loads_i.second_stage_valve) ? 16'h0 : v2_q + 16'h1;
  end

  // modes: 0 good, 1 no fuel, 2 dead air, 3 welded air, 4 stray light, 5 air drops, 6 flame drops
  always_comb begin
    air_flow_switch_o = loads_i.fan && fan_q > 16'h0028;
    flame_o           = loads_i.first_stage_valve;
    case (mode_i)
      3'h1: flame_o = 1'b0;
      3'h2: air_flow_switch_o = 1'b0;
      3'h3: air_flow_switch_o = 1'b1;
      3'h4: flame_o = loads_i.fan && !loads_i.ignition;
      3'h5: air_flow_switch_o = loads_i.fan && fan_q > 16'h0028 && fan_q < 16'h0bb8;
      3'h6: flame_o = loads_i.first_stage_valve && v2_q < 16'h0190;
      default: ;
    endcase
  end
endmodule : burner_far_side

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import burner_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        int_button_i = 1'b0;
  logic        remote_reset_button_i = 1'b0;
  logic        air_flow_switch_i;
  logic        flame_i;
  logic        thermostat_i = 1'b0;
  logic        mains_above_187_i = 1'b0;
  logic        mains_below_160_i = 1'b0;
  logic [2:0]  nv_cause_i = 3'h0;
  logic        nv_we_o;
  logic [2:0]  nv_cause_o;
  loads_t      loads_o;
  logic        remote_lockout_signal_o;
  logic        led_o;
  logic [2:0]  mode = 3'h0;
  logic [31:0] rd;
  int          failures = 0;
  int          samples_checked = 0;
  int          flashes;
  logic        led_seen;
  typedef struct { logic [2:0] mode; cause_t cause; } row_t;
  // partner fault mode beside the lockout cause it must produce
  row_t rows [6] = '{'{3'h1, C_SAFETY}, '{3'h2, C_AIRTMO}, '{3'h3, C_WELD},
                     '{3'h4, C_STRAY}, '{3'h5, C_AIROPN}, '{3'h6, C_FLLOSS}};

  always #25 clk_i = ~clk_i;

  burner_lockout_sequencer #(.TICK_CYC(4), .AIR_WAIT_T(50)) burner_lockout_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .int_button_i(int_button_i), .remote_reset_button_i(remote_reset_button_i),
    .air_flow_switch_i(air_flow_switch_i), .flame_i(flame_i), .thermostat_i(thermostat_i),
    .mains_above_187_i(mains_above_187_i), .mains_below_160_i(mains_below_160_i),
    .nv_cause_i(nv_cause_i), .nv_we_o(nv_we_o), .nv_cause_o(nv_cause_o), .loads_o(loads_o),
    .remote_lockout_signal_o(remote_lockout_signal_o), .led_o(led_o));

  burner_far_side burner_far_side_inst (
    .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .loads_i(loads_o),
    .air_flow_switch_o(air_flow_switch_i), .flame_o(flame_i));

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled, then released for at least a cycle
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask : wb

  // sel 1 waits on the lockout signal, sel 0 on the load pattern
  task wait_for(input logic sel, input logic [3:0] val, input int bound);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((sel ? {3'h0, remote_lockout_signal_o} : 4'(loads_o)) !== val && n < bound);
    if (n >= bound) begin
      failures++;
      tally_and_finish();
    end
  endtask : wait_for

  task press(input logic ext, input int len);
    @(posedge clk_i);
    if (ext)
      remote_reset_button_i <= 1'b1;
    else
      int_button_i <= 1'b1;
    repeat (len) @(posedge clk_i);
    remote_reset_button_i <= 1'b0;
    int_button_i <= 1'b0;
  endtask : press

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("loads after reset", 32'h0, {28'h0, loads_o});
    wb(1'b0, REG_STATUS, 32'h0);
    chk("state after reset", {20'h0, S_IDLE}, {20'h0, rd[11:0]});
    wb(1'b1, 8'h08, 32'hffffffff);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped read", 32'h0, rd);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("enable bit", 32'h1, {31'h0, rd[CTRL_EN]});
    // demand present but mains not proven high: nothing may start
    mode <= rows[0].mode;
    thermostat_i <= 1'b1;
    repeat (400) @(posedge clk_i);
    chk("loads on low mains", 32'h0, {28'h0, loads_o});
    mains_above_187_i <= 1'b1;
    foreach (rows[i]) begin
      wait_for(1'b1, 4'h1, 30000);
      chk("loads at lockout", 32'h0, {28'h0, loads_o});
      chk("nv write", 32'h1, {31'h0, nv_we_o});
      chk("cause", {29'h0, rows[i].cause}, {29'h0, nv_cause_o});
      repeat (400) @(posedge clk_i);
      chk("still locked", 32'h1, {31'h0, remote_lockout_signal_o});
      chk("indicator lit", 32'h1, {31'h0, led_o});
      mode <= (i < 5) ? rows[i + 1].mode : 3'h0;
      // alternate built-in and remote button so both reset paths are exercised
      press(i[0], 100);
      wait_for(1'b1, 4'h0, 200);
      chk("cause cleared", 32'h0, {29'h0, nv_cause_o});
    end
    wait_for(1'b0, 4'hd, 30000);
    mains_above_187_i <= 1'b0;
    mains_below_160_i <= 1'b1;
    wait_for(1'b0, 4'h0, 200);
    repeat (400) @(posedge clk_i);
    chk("loads in undervoltage", 32'h0, {28'h0, loads_o});
    mains_above_187_i <= 1'b1;
    mains_below_160_i <= 1'b0;
    wait_for(1'b0, 4'h1, 300);
    // a short press while sequencing is ignored, a long one locks out on release
    press(1'b1, 100);
    repeat (100) @(posedge clk_i);
    chk("short press", 32'h0, {31'h0, remote_lockout_signal_o});
    press(1'b0, 1400);
    wait_for(1'b1, 4'h1, 200);
    chk("manual cause", {29'h0, C_MANUAL}, {29'h0, nv_cause_o});
    wb(1'b1, REG_CTRL, 32'h3);
    wait_for(1'b1, 4'h0, 200);
    thermostat_i <= 1'b0;
    wait_for(1'b0, 4'h0, 300);
    // power returns with a stored cause: brief fan run, then locked again
    nv_cause_i <= 3'h5;
    thermostat_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_for(1'b0, 4'h1, 100);
    wait_for(1'b1, 4'h1, 2000);
    chk("restored cause", 32'h5, {29'h0, nv_cause_o});
    // past the lit phase: dark gap, then one flash per cause step
    repeat (4100) @(posedge clk_i);
    chk("dark gap", 32'h0, {31'h0, led_o});
    flashes = 0;
    led_seen = led_o;
    repeat (560) begin
      @(posedge clk_i);
      flashes += int'(led_o && !led_seen);
      led_seen = led_o;
    end
    chk("flash count", 32'h5, flashes);
    // bridged switch that opens during the quick lockout: the retry starts normally
    mode <= 3'h3;
    press(1'b0, 100);
    wait_for(1'b0, 4'h1, 300);
    wait_for(1'b0, 4'h0, 1200);
    mode <= 3'h0;
    repeat (4400) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("retry reaches prepurge", {20'h0, S_PURGE}, {20'h0, rd[11:0]});
    chk("second attempt flag", 32'h1, {31'h0, rd[ST_ATTEMPT]});
    tally_and_finish();
  end
endmodule : tb_top
